/* File: hdl/sac_sequencer.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
`default_nettype none
// Behaviour
// - ten-bit result, zero ground, full scale minus one
// - selections apply only while converter is enabled
// - right aligned default, left aligned on request
// - low byte read locks both result bytes
// - high byte read releases the lock
// - completion flag sets even when locked
// - start bit begins conversion, reads high, clears
// - channel change waits for current conversion
// - auto trigger rising edge resets prescaler, starts
// - held trigger or busy edges start nothing
// - trigger source flag cleared before next trigger
// - done-flag trigger converts continuously after first
// - start bit works in auto mode, reads busy
// - prescaler divides, held reset while disabled
// - software start waits first converter clock rising edge
// - conversion 13 cycles, first after enable 25
// - sample at 1.5, or 13.5 on first
// - completion writes result, sets flag, clears start
// - auto trigger samples at 2, lasts 13.5
// - free running restarts at once, start stays high
// - selection buffered, locked, reopened last cycle
module sac_sequencer #(
	parameter int TRIG_N = 8
) (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// register port
	input wire logic [sac_pkg::SAC_ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// trigger sources (index 0 is the done flag itself)
	input wire logic [TRIG_N-1:0] trig_src_in,
	// analog front end
	input wire logic [sac_pkg::SAC_RES_W-1:0] comparator_code_in,
	output logic [3:0] channel_select_out,
	output logic [1:0] reference_select_out,
	output logic sample_hold_out,
	output logic analog_enable_out,
	output logic conversion_irq_out
);
	import sac_pkg::*;

	// ============================================================
	// registers
	logic [7:0] ctrl_a_reg;
	logic [2:0] trigger_select_reg;
	logic [7:0] input_select_reg;
	logic [7:0] power_reg;
	logic [15:0] result_reg;
	logic lock_reg;
	logic trig_sync1_reg;
	logic trig_sync2_reg;
	logic trig_prev_reg;
	logic [3:0] channel_reg;
	logic [1:0] ref_reg;
	logic [7:0] presc_reg;
	logic half_tick_reg;
	logic first_reg;
	logic auto_conv_reg;
	logic [5:0] half_cnt_reg;
	logic sample_reg;
	logic irq_reg;
	logic [7:0] rdata_reg;
	sac_state_t state_reg;

	logic enabled;
	logic wr_a, wr_start, trig_level, trig_rise, auto_fire, done, free_mode;
	logic [5:0] end_half, sample_half;
	logic [7:0] presc_half;

	assign enabled = ctrl_a_reg[SAC_CA_EN] && !power_reg[0];
	assign wr_a = wr_in && addr_in == SAC_OFS_CTRL_A;
	assign wr_start = wr_a && wdata_in[SAC_CA_START] && enabled;
	assign free_mode = ctrl_a_reg[SAC_CA_AUTO] && trigger_select_reg == SAC_TRIG_FREE;

	// ============================================================
	// trigger synchronisation and edge detect
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trig_sync1_reg <= 1'b0;
			trig_sync2_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_sync1_reg <= trig_src_in[trigger_select_reg];
			trig_sync2_reg <= trig_sync1_reg;
			trig_prev_reg <= trig_level;
		end
	end
	// source 0 is the done flag itself, it needs no synchroniser
	assign trig_level = (trigger_select_reg == SAC_TRIG_FREE) ? ctrl_a_reg[SAC_CA_DONE]
		: trig_sync2_reg;
	// edges seen while busy are dropped: no pending latch
	assign trig_rise = trig_level && !trig_prev_reg;
	// the source flag must fall before a new rise is seen
	assign auto_fire = ctrl_a_reg[SAC_CA_AUTO] && enabled && trig_rise && state_reg == SAC_IDLE
		&& trigger_select_reg != SAC_TRIG_FREE;

	// ============================================================
	// prescaler: produces a tick per converter clock half period
	assign presc_half = 8'h01 << (ctrl_a_reg[2:0] == 3'h0 ? 3'h0 : ctrl_a_reg[2:0] - 3'h1);
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			presc_reg <= 8'h00;
			half_tick_reg <= 1'b0;
		end else if (!enabled || auto_fire) begin
			presc_reg <= 8'h00;
			half_tick_reg <= 1'b0;
		end else if (presc_reg >= presc_half - 8'h01) begin
			presc_reg <= 8'h00;
			half_tick_reg <= 1'b1;
		end else begin
			presc_reg <= presc_reg + 8'h01;
			half_tick_reg <= 1'b0;
		end
	end

	// ============================================================
	// conversion sequencer, counted in converter half cycles
	// a phase bit tracks converter clock level so starts land on a rising edge
	logic phase_reg;
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_reg <= 1'b0;
		end else if (!enabled || auto_fire) begin
			phase_reg <= 1'b0;
		end else if (half_tick_reg) begin
			phase_reg <= !phase_reg;
		end
	end

	assign end_half = auto_conv_reg ? SAC_AUTO_HALF_LEN
		: (first_reg ? SAC_FIRST_CYC << 1 : SAC_NORMAL_CYC << 1);
	assign sample_half = auto_conv_reg ? SAC_AUTO_HALF_SAMPLE
		: (first_reg ? SAC_FIRST_HALF_SAMPLE : SAC_NORMAL_HALF_SAMPLE);
	assign done = state_reg == SAC_CONV && half_tick_reg && half_cnt_reg == end_half - 6'h01;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= SAC_IDLE;
			half_cnt_reg <= 6'h00;
			auto_conv_reg <= 1'b0;
		end else if (!enabled) begin
			state_reg <= SAC_IDLE;
			half_cnt_reg <= 6'h00;
			auto_conv_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				SAC_IDLE: begin
					half_cnt_reg <= 6'h00;
					if (auto_fire) begin
						state_reg <= SAC_CONV;
						auto_conv_reg <= 1'b1;
					end else if (wr_start) begin
						state_reg <= SAC_ARMED;
						auto_conv_reg <= 1'b0;
					end
				end
				SAC_ARMED: begin
					// low phase about to rise: next half tick is a rising edge
					if (half_tick_reg && !phase_reg) begin
						state_reg <= SAC_CONV;
					end
				end
				SAC_CONV: begin
					if (half_tick_reg) begin
						half_cnt_reg <= half_cnt_reg + 6'h01;
					end
					if (done) begin
						half_cnt_reg <= 6'h00;
						auto_conv_reg <= 1'b0;
						// free running restarts with no gap
						state_reg <= free_mode ? SAC_CONV : SAC_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			first_reg <= 1'b1;
		end else if (!enabled) begin
			first_reg <= 1'b1;
		end else if (done) begin
			first_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sample_reg <= 1'b0;
		end else begin
			sample_reg <= state_reg == SAC_CONV && half_cnt_reg < sample_half;
		end
	end

	// ============================================================
	// channel and reference buffering
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			channel_reg <= 4'h0;
			ref_reg <= 2'h0;
		end else if (enabled && (state_reg != SAC_CONV
			|| half_cnt_reg >= end_half - 6'h02)) begin
			channel_reg <= input_select_reg[3:0];
			ref_reg <= input_select_reg[7:6];
		end
	end

	// ============================================================
	// software registers
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_a_reg <= 8'h00;
		end else begin
			if (wr_a) begin
				ctrl_a_reg[SAC_CA_EN] <= wdata_in[SAC_CA_EN];
				ctrl_a_reg[SAC_CA_AUTO] <= wdata_in[SAC_CA_AUTO];
				ctrl_a_reg[SAC_CA_IRQEN] <= wdata_in[SAC_CA_IRQEN];
				ctrl_a_reg[2:0] <= wdata_in[2:0];
			end
			// start bit reads one through every conversion
			ctrl_a_reg[SAC_CA_START] <= wr_start || (enabled && (state_reg != SAC_IDLE)
				&& !(done && !free_mode));
			// set wins over write-one-to-clear
			if (done) begin
				ctrl_a_reg[SAC_CA_DONE] <= 1'b1;
			end else if (wr_a && wdata_in[SAC_CA_DONE]) begin
				ctrl_a_reg[SAC_CA_DONE] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trigger_select_reg <= 3'h0;
			input_select_reg <= 8'h00;
			power_reg <= SAC_POWER_RST;
		end else if (wr_in) begin
			if (addr_in == SAC_OFS_CTRL_B) begin
				trigger_select_reg <= wdata_in[2:0];
			end
			if (addr_in == SAC_OFS_INPUT) begin
				input_select_reg <= wdata_in;
			end
			if (addr_in == SAC_OFS_POWER) begin
				power_reg <= {7'h00, wdata_in[0]};
			end
		end
	end

	// ============================================================
	// result bytes and read lock
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			result_reg <= 16'h0000;
		end else if (done && !lock_reg) begin
			// comparator code is zero at ground, 3ff at reference minus one step
			result_reg <= input_select_reg[SAC_IN_LEFT] ? {comparator_code_in, 6'h00}
				: {6'h00, comparator_code_in};
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lock_reg <= 1'b0;
		end else if (rd_in && addr_in == SAC_OFS_RES_HIGH) begin
			lock_reg <= 1'b0;
		end else if (rd_in && addr_in == SAC_OFS_RES_LOW) begin
			lock_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_reg <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				SAC_OFS_CTRL_A: rdata_reg <= ctrl_a_reg;
				SAC_OFS_CTRL_B: rdata_reg <= {5'h00, trigger_select_reg};
				SAC_OFS_INPUT: rdata_reg <= input_select_reg;
				SAC_OFS_RES_LOW: rdata_reg <= result_reg[7:0];
				SAC_OFS_RES_HIGH: rdata_reg <= result_reg[15:8];
				SAC_OFS_POWER: rdata_reg <= power_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ctrl_a_reg[SAC_CA_DONE] && ctrl_a_reg[SAC_CA_IRQEN];
		end
	end

	assign rdata_out = rdata_reg;
	assign conversion_irq_out = irq_reg;
	assign sample_hold_out = sample_reg;
	assign channel_select_out = channel_reg;
	assign reference_select_out = ref_reg;
	assign analog_enable_out = ctrl_a_reg[SAC_CA_EN];

	// ============================================================
	// checks
	sequence s_low_read;
		rd_in && addr_in == SAC_OFS_RES_LOW && !(rd_in && addr_in == SAC_OFS_RES_HIGH);
	endsequence
	property p_lock_holds;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		lock_reg && done |=> $stable(result_reg);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked result changed");
	property p_lock_set;
		@(posedge clk_sys_in) disable iff (!rst_b_in) s_low_read |=> lock_reg;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("low read did not lock");
	property p_unlock;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		rd_in && addr_in == SAC_OFS_RES_HIGH |=> !lock_reg;
	endproperty
	a_unlock: assert property (p_unlock) else $error("high read did not unlock");
	property p_done_flag;
		@(posedge clk_sys_in) disable iff (!rst_b_in) done |=> ctrl_a_reg[SAC_CA_DONE];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("done flag missing");
	// a disable drops a conversion in flight, so busy means converting and enabled
	property p_busy_start;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		enabled && state_reg == SAC_CONV && !done |=> ctrl_a_reg[SAC_CA_START];
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("start low while busy");
	property p_disabled_idle;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!enabled |=> state_reg == SAC_IDLE && presc_reg == 8'h00;
	endproperty
	a_disabled_idle: assert property (p_disabled_idle) else $error("runs while off");
	property p_irq;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		ctrl_a_reg[SAC_CA_DONE] && ctrl_a_reg[SAC_CA_IRQEN] |=> conversion_irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");
	property p_sel_lock;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		state_reg == SAC_CONV && half_cnt_reg < 6'h04 && !done |=> $stable(channel_reg);
	endproperty
	a_sel_lock: assert property (p_sel_lock) else $error("channel moved mid conversion");
	property p_single_end;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		done && !free_mode && !wr_start |=> !ctrl_a_reg[SAC_CA_START] && state_reg == SAC_IDLE;
	endproperty
	a_single_end: assert property (p_single_end) else $error("start bit not cleared");
	property p_auto_restart;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		auto_fire |=> presc_reg == 8'h00 && state_reg == SAC_CONV;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("trigger did not start");
	property p_free_restart;
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		done && free_mode && enabled |=> state_reg == SAC_CONV && ctrl_a_reg[SAC_CA_START];
	endproperty
	a_free_restart: assert property (p_free_restart) else $error("free run stopped");
endmodule
`default_nettype wire

/* File: hdl/sac_pkg.sv */
`default_nettype none
package sac_pkg;
	// register map, one byte register per word offset
	localparam logic [2:0] SAC_OFS_CTRL_A = 3'h0;
	localparam logic [2:0] SAC_OFS_CTRL_B = 3'h1;
	localparam logic [2:0] SAC_OFS_INPUT = 3'h2;
	localparam logic [2:0] SAC_OFS_RES_LOW = 3'h3;
	localparam logic [2:0] SAC_OFS_RES_HIGH = 3'h4;
	localparam logic [2:0] SAC_OFS_POWER = 3'h5;
	localparam int SAC_ADDR_W = 3;
	// converter_control_a fields
	localparam int SAC_CA_EN = 7;
	localparam int SAC_CA_START = 6;
	localparam int SAC_CA_AUTO = 5;
	localparam int SAC_CA_DONE = 4;
	localparam int SAC_CA_IRQEN = 3;
	// input_select_reg fields
	localparam int SAC_IN_LEFT = 5;
	localparam logic [7:0] SAC_POWER_RST = 8'h01;
	// conversion timing: CYC constants in converter clock cycles, HALF constants in half cycles
	localparam logic [5:0] SAC_NORMAL_CYC = 6'h0d;
	localparam logic [5:0] SAC_FIRST_CYC = 6'h19;
	localparam logic [5:0] SAC_NORMAL_HALF_SAMPLE = 6'h03;
	localparam logic [5:0] SAC_FIRST_HALF_SAMPLE = 6'h1b;
	localparam logic [5:0] SAC_AUTO_HALF_SAMPLE = 6'h04;
	localparam logic [5:0] SAC_AUTO_HALF_LEN = 6'h1b;
	localparam logic [2:0] SAC_TRIG_FREE = 3'h0;
	localparam int SAC_RES_W = 10;
	typedef enum logic [1:0] {SAC_IDLE, SAC_ARMED, SAC_CONV} sac_state_t;
endpackage
`default_nettype wire

/* File: sim/sac_front_model.sv */
`default_nettype none
// ==========================================
// analog front end: holds a code per channel
module sac_front_model (
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	// selections from the sequencer
	input wire logic [3:0] channel_select_in,
	input wire logic [1:0] reference_select_in,
	input wire logic sample_hold_in,
	input wire logic analog_enable_in,
	// code to the sequencer
	output logic [9:0] code_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] held_reg;
	logic [9:0] junk_reg;
	logic valid_reg;
	logic hold_d_reg;
	// outside a hold the code wanders, so a late sample never looks right by luck
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			held_reg <= 10'h000;
			junk_reg <= 10'h2aa;
			valid_reg <= 1'b0;
			hold_d_reg <= 1'b0;
		end else begin
			junk_reg <= ~junk_reg;
			hold_d_reg <= sample_hold_in;
			if (!analog_enable_in || sample_hold_in) begin
				valid_reg <= 1'b0;
			end else if (hold_d_reg) begin
				valid_reg <= 1'b1;
				held_reg <= {channel_select_in, reference_select_in, 4'h9};
			end
		end
	end
	assign code_out = valid_reg ? held_reg : junk_reg;
endmodule
`default_nettype wire

/* File: sim/tb_sac_sequencer.sv */
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
// ==========================================
// bench top
module tb_sac_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	import sac_pkg::*;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [2:0] addr_in = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] trig_src_in = 8'h00;
	logic [7:0] rdata_out;
	logic [9:0] code;
	logic [3:0] chan;
	logic [1:0] refs;
	logic sh;
	logic aen;
	logic irq;
	logic [7:0] rd_v;
	logic [9:0] e;
	int failures = 0;
	int tests_run = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	sac_sequencer #(.TRIG_N(8)) dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .trig_src_in(trig_src_in), .comparator_code_in(code),
		.channel_select_out(chan), .reference_select_out(refs), .sample_hold_out(sh),
		.analog_enable_out(aen), .conversion_irq_out(irq));
	sac_front_model model_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.channel_select_in(chan), .reference_select_in(refs), .sample_hold_in(sh),
		.analog_enable_in(aen), .code_out(code));
	// ==========================================
	// bus tasks
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		rd_v = rdata_out;
	endtask
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] x);
		rd(a);
		`CHK(rd_v, x)
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask
	// polls the done flag, bounded so a dead converter cannot hang the run
	task automatic wait_done();
		int n;
		n = 0;
		rd_v = 8'h00;
		while (rd_v[SAC_CA_DONE] !== 1'b1 && n < 300) begin
			rd(SAC_OFS_CTRL_A);
			n++;
		end
		`CHK(rd_v[SAC_CA_DONE], 1'b1)
	endtask
	function automatic logic [9:0] exp_code(input logic [3:0] c);
		return {c, 2'h1, 4'h9};
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
	// ==========================================
	// tests; prescale 1 keeps runs short, resolution is not modelled
	initial begin
		idle(2);
		rst_b_in <= 1'b1;
		rd_chk(SAC_OFS_CTRL_A, 8'h00);
		rd_chk(SAC_OFS_POWER, SAC_POWER_RST);
		wr(3'h7, 8'hff);
		rd_chk(3'h7, 8'h00);
		wr(SAC_OFS_CTRL_A, 8'hc1);
		idle(80);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[6:4], 3'b000)
		wr(SAC_OFS_CTRL_A, 8'h00);
		wr(SAC_OFS_INPUT, 8'h49);
		idle(4);
		`CHK(chan == 4'h9, 1'b0)
		$display("test reset done");
		wr(SAC_OFS_POWER, 8'h00);
		// full resolution is not asked for here, so a fast converter clock is allowed
		wr(SAC_OFS_CTRL_A, 8'h89);
		idle(4);
		`CHK(chan, 4'h9)
		`CHK(refs, 2'h1)
		`CHK(aen, 1'b1)
		wr(SAC_OFS_INPUT, 8'h45);
		wr(SAC_OFS_CTRL_A, 8'hc9);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[SAC_CA_START], 1'b1)
		wait_done();
		`CHK(rd_v[SAC_CA_START], 1'b0)
		`CHK(irq, 1'b1)
		wr(SAC_OFS_CTRL_A, 8'h99);
		idle(3);
		`CHK(irq, 1'b0)
		e = exp_code(4'h5);
		rd_chk(SAC_OFS_RES_LOW, e[7:0]);
		rd_chk(SAC_OFS_RES_HIGH, {6'h00, e[9:8]});
		$display("test single done");
		rd(SAC_OFS_RES_LOW);
		wr(SAC_OFS_INPUT, 8'h42);
		wr(SAC_OFS_CTRL_A, 8'hc9);
		wait_done();
		`CHK(irq, 1'b1)
		wr(SAC_OFS_CTRL_A, 8'h99);
		rd_chk(SAC_OFS_RES_HIGH, {6'h00, e[9:8]});
		wr(SAC_OFS_CTRL_A, 8'hc9);
		wr(SAC_OFS_INPUT, 8'h66);
		wait_done();
		wr(SAC_OFS_CTRL_A, 8'h99);
		e = exp_code(4'h2);
		rd_chk(SAC_OFS_RES_LOW, {e[1:0], 6'h00});
		rd_chk(SAC_OFS_RES_HIGH, e[9:2]);
		$display("test lock done");
		wr(SAC_OFS_INPUT, 8'h46);
		wr(SAC_OFS_CTRL_B, {5'h00, SAC_TRIG_FREE});
		wr(SAC_OFS_CTRL_A, 8'he9);
		wait_done();
		`CHK(rd_v[SAC_CA_START], 1'b1)
		wr(SAC_OFS_CTRL_A, 8'hb9);
		wait_done();
		e = exp_code(4'h6);
		rd_chk(SAC_OFS_RES_LOW, e[7:0]);
		rd_chk(SAC_OFS_RES_HIGH, {6'h00, e[9:8]});
		wr(SAC_OFS_CTRL_A, 8'h19);
		idle(4);
		`CHK(aen, 1'b0)
		$display("test free run done");
		wr(SAC_OFS_CTRL_B, 8'h03);
		// the enable write also clears the done flag, which the disable write above already cleared
		wr(SAC_OFS_CTRL_A, 8'hb9);
		idle(40);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[6:4], 3'b010)
		idle(1);
		trig_src_in[3] <= 1'b1;
		idle(8);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[SAC_CA_START], 1'b1)
		idle(1);
		// the source falls before it may fire again
		trig_src_in[3] <= 1'b0;
		idle(2);
		trig_src_in[3] <= 1'b1;
		wait_done();
		wr(SAC_OFS_CTRL_A, 8'hb9);
		idle(100);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[6:4], 3'b010)
		wr(SAC_OFS_CTRL_A, 8'he9);
		rd(SAC_OFS_CTRL_A);
		`CHK(rd_v[SAC_CA_START], 1'b1)
		wait_done();
		$display("test auto done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
